// [hbs_fault_supervisor.sv]
`include "hbs_map.svh"
module hbs_fault_supervisor
  import hbs_pkg::*;
#(
  parameter int OL_FILT_CYC = `HBS_OL_FILT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic en,
  input wire logic [7:0] oc_hs,
  input wire logic [7:0] oc_ls,
  input wire logic [7:0] ol_hs,
  input wire logic [7:0] ol_ls,
  input wire logic [7:0] fw_hs,
  input wire logic [7:0] fw_ls,
  input wire logic temp_warn,
  input wire logic temp_sd,
  input wire logic supply_undervoltage_flag,
  input wire logic supply_overvoltage_flag,
  output logic [7:0] gate_hs,
  output logic [7:0] gate_ls,
  output logic [1:0] led_sel
);

  localparam logic [7:0] DEAD = 8'(`HBS_DEAD_CYC);
  localparam logic [15:0] OC_F = 16'(`HBS_OC_FILT_CYC);
  localparam logic [15:0] OL_F = 16'(OL_FILT_CYC);
  localparam logic [15:0] LED_F = 16'(`HBS_LED_FILT_CYC);

  hbs_state_t s;
  hbs_state_t n;
  logic allowed;
  logic addr_ok;
  logic [15:0] oc_in;
  logic [15:0] ol_in;
  logic [15:0] fw_in;
  logic [15:0] g;
  logic [15:0] filt;
  logic [7:0] want_h;
  logic [7:0] want_l;
  logic glb_wr;
  logic [7:0] glb_clr;

  assign oc_in = {oc_ls, oc_hs};
  assign ol_in = {ol_ls, ol_hs};
  assign fw_in = {fw_ls, fw_hs};
  assign g = {s.gl, s.gh};
  assign addr_ok = hsel & hready & htrans[1];
  assign glb_wr = s.wr_pend & (s.waddr == `HBS_OFF_GLOBAL);
  assign glb_clr = glb_wr ? hwdata[7:0] : 8'h00;
  // live supply faults drop the stages at once; they come back by themselves
  // a temperature warning is deliberately absent here: it only reports
  assign allowed = en & ~s.temp_shutdown_flag & ~supply_undervoltage_flag & ~supply_overvoltage_flag;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    // register writes land in the data phase
    if (s.wr_pend) begin
      case (s.waddr)
        `HBS_OFF_HS_EN: n.hs_en = hwdata[7:0];
        `HBS_OFF_LS_EN: n.ls_en = hwdata[7:0];
        `HBS_OFF_OL_CTRL: n.led = hwdata[1:0];
        `HBS_OFF_GLOBAL: begin
          if (hwdata[`HBS_BIT_TPW]) n.temp_prewarning_flag = 1'b0;
          if (hwdata[`HBS_BIT_TSD]) n.temp_shutdown_flag = 1'b0;
          if (hwdata[`HBS_BIT_UV]) n.uv = 1'b0;
          if (hwdata[`HBS_BIT_OV]) n.ov = 1'b0;
          // clearing the reset indication only counts in normal mode
          if (hwdata[`HBS_BIT_NEGATED_POWER_ON_RESET_BIT] && en) n.negated_power_on_reset_bit = 1'b1;
        end
        `HBS_OFF_OC: n.oc = s.oc & ~hwdata[15:0];
        `HBS_OFF_OL: n.ol = s.ol & ~hwdata[15:0];
        default: ;
      endcase
    end
    // hardware sets after the clears so a coincident event wins
    if (temp_warn) n.temp_prewarning_flag = 1'b1;
    if (temp_sd) n.temp_shutdown_flag = 1'b1;
    if (supply_undervoltage_flag) n.uv = 1'b1;
    if (supply_overvoltage_flag) n.ov = 1'b1;
    // per-switch filters; index 0..7 high sides, 8..15 low sides
    for (int j = 0; j < 16; j++) begin
      filt[j] = 1'b0;
      if (g[j] && oc_in[j]) begin
        filt[j] = (s.occ[j] == OC_F - 16'h0001);
        if (!filt[j]) n.occ[j] = s.occ[j] + 16'h0001;
        if (filt[j]) n.oc[j] = 1'b1;
      end else begin
        n.occ[j] = 16'h0000;
      end
      // free-wheeling stages see no load current by design
      if (g[j] && ol_in[j] && !fw_in[j]) begin
        if (j < 2 && s.led[j[0]]) begin
          if (s.olc[j] == LED_F - 16'h0001) n.ol[j] = 1'b1;
          else n.olc[j] = s.olc[j] + 16'h0001;
        end else begin
          if (s.olc[j] == OL_F - 16'h0001) n.ol[j] = 1'b1;
          else n.olc[j] = s.olc[j] + 16'h0001;
        end
      end else begin
        n.olc[j] = 16'h0000;
      end
    end
    // gate drive; enable bits are never touched by faults
    for (int i = 0; i < 8; i++) begin
      want_h[i] = s.hs_en[i] & ~s.ls_en[i] & allowed & ~s.oc[i];
      want_l[i] = s.ls_en[i] & ~s.hs_en[i] & allowed & ~s.oc[i + 8];
      // a side turns on only once the other is off and the gap has run out
      n.gh[i] = want_h[i] & (s.gh[i] | (~s.gl[i] & (s.dt[i] == 8'h00)));
      n.gl[i] = want_l[i] & (s.gl[i] | (~s.gh[i] & (s.dt[i] == 8'h00)));
      if ((s.gh[i] & ~n.gh[i]) | (s.gl[i] & ~n.gl[i])) n.dt[i] = DEAD;
      else if (s.dt[i] != 8'h00) n.dt[i] = s.dt[i] - 8'h01;
    end
    // bus address phase; zero wait states, always OKAY
    n.wr_pend = addr_ok & hwrite;
    n.waddr = haddr[7:0];
    n.rdata = 32'h00000000;
    if (addr_ok && !hwrite && haddr[31:8] == 24'h000000) begin
      case (haddr[7:0])
        `HBS_OFF_HS_EN: n.rdata[7:0] = n.hs_en;
        `HBS_OFF_LS_EN: n.rdata[7:0] = n.ls_en;
        `HBS_OFF_OL_CTRL: n.rdata[1:0] = n.led;
        `HBS_OFF_GLOBAL: begin
          n.rdata[`HBS_BIT_NEGATED_POWER_ON_RESET_BIT] = n.negated_power_on_reset_bit;
          n.rdata[`HBS_BIT_TPW] = n.temp_prewarning_flag;
          n.rdata[`HBS_BIT_TSD] = n.temp_shutdown_flag;
          n.rdata[`HBS_BIT_OV] = n.ov;
          n.rdata[`HBS_BIT_UV] = n.uv;
          n.rdata[`HBS_BIT_LE] = |{n.oc, n.ol};
        end
        `HBS_OFF_OC: n.rdata[15:0] = n.oc;
        `HBS_OFF_OL: n.rdata[15:0] = n.ol;
        `HBS_OFF_GATES: n.rdata[15:0] = {n.gl, n.gh};
        default: ;
      endcase
    end
    n.rdy = 1'b1;
    n.resp = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // hresetn is the logic-supply reset: all stages off, negated_power_on_reset_bit reads 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.rdy;
  assign hresp = s.resp;
  assign hrdata = s.rdata;
  assign gate_hs = s.gh;
  assign gate_ls = s.gl;
  assign led_sel = s.led;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_no_cross_cond: assert property ((s.gh & s.gl) == 8'h00)
    else $error("both switches of a bridge on");
  a_dead_gap: assert property ((s.gh[0] ##1 !s.gh[0]) |-> !s.gl[0] [*8])
    else $error("low side on inside dead time");
  a_oc_shut_off: assert property ($rose(s.oc[0]) |=> !s.gh[0] && s.hs_en == $past(s.hs_en))
    else $error("overcurrent did not shut switch off");
  a_oc_stays_off: assert property (s.oc[0] |=> !s.gh[0])
    else $error("switch on while overcurrent flag set");
  a_tsd_all_off: assert property (s.temp_shutdown_flag |=> (s.gh == 8'h00) && (s.gl == 8'h00))
    else $error("outputs on during temperature shutdown");
  a_tpw_holds: assert property (s.temp_prewarning_flag && !glb_clr[`HBS_BIT_TPW] |=> s.temp_prewarning_flag)
    else $error("warning flag lost without clear");
  a_tpw_hot_stays: assert property (temp_warn |=> s.temp_prewarning_flag)
    else $error("warning flag cleared while hot");
  a_uv_off_latch: assert property (supply_undervoltage_flag |=> s.uv ##0 (s.gh == 8'h00))
    else $error("undervoltage not handled");
  a_ov_off_latch: assert property (supply_overvoltage_flag |=> s.ov && (s.gl == 8'h00))
    else $error("overvoltage not handled");
  a_le_on_read: assert property (addr_ok && !hwrite && haddr[7:0] == `HBS_OFF_GLOBAL
      && !s.wr_pend && (s.oc != 16'h0000) |=> hrdata[`HBS_BIT_LE])
    else $error("load error not reported");

  ////////////////////////////////////////////////////////////////////////////
  // bus side: zero wait states and a fixed OKAY response
  a_ready_high: assert property ($past(hresetn) |-> hreadyout)
    else $error("ready low outside reset");

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response given");

  // reset indication only leaves 0 through a host write in normal mode
  a_negated_power_on_reset_bit_holds: assert property (s.negated_power_on_reset_bit |=> s.negated_power_on_reset_bit)
    else $error("reset indication dropped without reset");

  a_negated_power_on_reset_bit_needs_en: assert property (!s.negated_power_on_reset_bit && !en |=> !s.negated_power_on_reset_bit)
    else $error("reset indication set outside normal mode");

  ////////////////////////////////////////////////////////////////////////////
  // latched supply and temperature flags hold until written 1
  a_tsd_holds: assert property (s.temp_shutdown_flag && !glb_clr[`HBS_BIT_TSD] |=> s.temp_shutdown_flag)
    else $error("shutdown flag lost without clear");

  a_uv_holds: assert property (s.uv && !glb_clr[`HBS_BIT_UV] |=> s.uv)
    else $error("undervoltage flag lost without clear");

  a_ov_holds: assert property (s.ov && !glb_clr[`HBS_BIT_OV] |=> s.ov)
    else $error("overvoltage flag lost without clear");

  a_tsd_sets: assert property (temp_sd |=> s.temp_shutdown_flag)
    else $error("shutdown flag not set");

  a_uv_gates_ls: assert property (supply_undervoltage_flag |=> (s.gl == 8'h00))
    else $error("low side on during undervoltage");

  a_ov_gates_hs: assert property (supply_overvoltage_flag |=> (s.gh == 8'h00))
    else $error("high side on during overvoltage");

  // a warning alone must leave a running stage running
  a_tpw_no_off: assert property (temp_warn && !temp_sd && !supply_undervoltage_flag && !supply_overvoltage_flag && en
      && s.gh[0] && s.hs_en[0] && !s.ls_en[0] && !s.oc[0] && !s.temp_shutdown_flag
      && !s.wr_pend |=> s.gh[0])
    else $error("warning switched an output off");

  // supplies back in range: a waiting stage comes back by itself
  a_supply_recover: assert property (!supply_undervoltage_flag && !supply_overvoltage_flag && en && !s.temp_shutdown_flag && s.hs_en[0]
      && !s.ls_en[0] && !s.oc[0] && !s.gl[0] && (s.dt[0] == 8'h00)
      && !s.wr_pend |=> s.gh[0])
    else $error("output not reactivated");

  a_enable_kept: assert property (s.temp_shutdown_flag && !s.wr_pend |=> s.hs_en == $past(s.hs_en))
    else $error("enable bits changed by shutdown");

  ////////////////////////////////////////////////////////////////////////////
  // dead time in the other direction too
  a_dead_gap_lh: assert property ((s.gl[0] ##1 !s.gl[0]) |-> !s.gh[0] [*8])
    else $error("high side on inside dead time");

  // filters run their full length before a flag appears
  a_oc_filter_len: assert property ($rose(s.oc[0]) |-> $past(s.occ[0]) == OC_F - 16'h0001)
    else $error("overcurrent flag before filter end");

  a_ol_filter_len: assert property ($rose(s.ol[0]) && !$past(s.led[0])
      |-> $past(s.olc[0]) == OL_F - 16'h0001)
    else $error("open-load flag before filter end");

  a_led_filter_len: assert property ($rose(s.ol[0]) && $past(s.led[0])
      |-> $past(s.olc[0]) == LED_F - 16'h0001)
    else $error("led open-load flag before filter end");

  // blanking: a free-wheeling stage never gains an open-load flag
  a_fw_blank: assert property (fw_hs[0] && !s.ol[0] |=> !s.ol[0])
    else $error("open load flagged while free-wheeling");

  // a clear that meets a confirmed event loses to it
  a_oc_set_wins: assert property (s.wr_pend && (s.waddr == `HBS_OFF_OC) && hwdata[0]
      && s.gh[0] && oc_in[0] && (s.occ[0] == OC_F - 16'h0001) |=> s.oc[0])
    else $error("overcurrent event lost to clear");

  c_oc_event: cover property ($rose(s.oc[0]));
  c_ol_event: cover property ($rose(s.ol[0]));
  c_tsd_recover: cover property (s.temp_shutdown_flag ##1 !s.temp_shutdown_flag ##[1:40] s.gh[0]);
  c_reverse: cover property ($fell(s.gh[1]) ##[1:40] $rose(s.gl[1]));

endmodule : hbs_fault_supervisor

// [hbs_map.svh]
`ifndef HBS_MAP_SVH
`define HBS_MAP_SVH
// register byte offsets
`define HBS_OFF_HS_EN 8'h00
`define HBS_OFF_LS_EN 8'h04
`define HBS_OFF_OL_CTRL 8'h08
`define HBS_OFF_GLOBAL 8'h0C
`define HBS_OFF_OC 8'h10
`define HBS_OFF_OL 8'h14
`define HBS_OFF_GATES 8'h18
// global status bit positions
`define HBS_BIT_NEGATED_POWER_ON_RESET_BIT 0
`define HBS_BIT_TPW 1
`define HBS_BIT_TSD 2
`define HBS_BIT_OV 4
`define HBS_BIT_UV 5
`define HBS_BIT_LE 6
// timing
`define HBS_CLK_NS 20
`define HBS_DEAD_NS 500
`define HBS_DEAD_CYC ((`HBS_DEAD_NS + `HBS_CLK_NS - 1) / `HBS_CLK_NS)
`define HBS_OC_FILT_NS 10000
`define HBS_OC_FILT_CYC ((`HBS_OC_FILT_NS + `HBS_CLK_NS - 1) / `HBS_CLK_NS)
`define HBS_OL_FILT_NS 200000
`define HBS_OL_FILT_CYC ((`HBS_OL_FILT_NS + `HBS_CLK_NS - 1) / `HBS_CLK_NS)
`define HBS_LED_FILT_NS 20000
`define HBS_LED_FILT_CYC ((`HBS_LED_FILT_NS + `HBS_CLK_NS - 1) / `HBS_CLK_NS)
`endif

// [hbs_pkg.sv]
package hbs_pkg;
  typedef struct packed {
    logic [7:0] hs_en;
    logic [7:0] ls_en;
    logic [1:0] led;
    logic temp_prewarning_flag;
    logic temp_shutdown_flag;
    logic uv;
    logic ov;
    logic negated_power_on_reset_bit;
    logic [15:0] oc;
    logic [15:0] ol;
    logic [7:0] gh;
    logic [7:0] gl;
    logic [7:0][7:0] dt;
    logic [15:0][15:0] occ;
    logic [15:0][15:0] olc;
    logic wr_pend;
    logic [7:0] waddr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
  } hbs_state_t;
endpackage : hbs_pkg

// [hbs_load_model.sv]
module hbs_load_model (
  input wire logic [7:0] gate_hs,
  input wire logic [7:0] gate_ls,
  input wire logic [15:0] short_m,
  input wire logic [15:0] open_m,
  output logic [7:0] oc_hs,
  output logic [7:0] oc_ls,
  output logic [7:0] ol_hs,
  output logic [7:0] ol_ls
);
  timeunit 1ns;
  timeprecision 1ps;
  // a shorted or missing load only shows while its switch conducts,
  // so a switch that the block shut off stops reporting at once
  assign oc_hs = gate_hs & short_m[7:0];
  assign oc_ls = gate_ls & short_m[15:8];
  assign ol_hs = gate_hs & open_m[7:0];
  assign ol_ls = gate_ls & open_m[15:8];
endmodule : hbs_load_model

// [hbs_fault_supervisor_tb_top.sv]
module hbs_fault_supervisor_tb_top;
  import hbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, en = 1, hready, hresp;
  logic temp_warn = 0, temp_sd = 0, supply_undervoltage_flag = 0, supply_overvoltage_flag = 0;
  logic [1:0] htrans = 2'h0, led_sel;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [7:0] fw_hs = 8'h00, gate_hs, gate_ls, oc_hs, oc_ls, ol_hs, ol_ls;
  logic [15:0] short_m = 16'h0000, open_m = 16'h0000;
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #10 hclk = ~hclk;
  hbs_load_model load (.gate_hs(gate_hs), .gate_ls(gate_ls), .short_m(short_m),
    .open_m(open_m), .oc_hs(oc_hs), .oc_ls(oc_ls), .ol_hs(ol_hs), .ol_ls(ol_ls));
  hbs_fault_supervisor #(.OL_FILT_CYC(20)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .en(en), .oc_hs(oc_hs), .oc_ls(oc_ls), .ol_hs(ol_hs),
    .ol_ls(ol_ls), .fw_hs(fw_hs), .fw_ls(8'h00), .temp_warn(temp_warn),
    .temp_sd(temp_sd), .supply_undervoltage_flag(supply_undervoltage_flag), .supply_overvoltage_flag(supply_overvoltage_flag), .gate_hs(gate_hs),
    .gate_ls(gate_ls), .led_sel(led_sel));
  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    v = hrdata;
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    xfer(8'h0C, 0, 0); chk(v[0], 0);
    chk(hresp, 0);
    xfer(8'h40, 0, 0); chk(v, 0);
    xfer(8'h0C, 1, 32'h1); xfer(8'h0C, 0, 0); chk(v[0], 1);
    $display("reset test done");
  endtask : t_reset
  task t_dead;
    xfer(8'h00, 1, 32'h1); wt(30); chk(gate_hs, 8'h01);
    xfer(8'h00, 1, 0); xfer(8'h04, 1, 32'h1); chk(gate_ls, 0);
    wt(30); chk(gate_ls, 8'h01);
    xfer(8'h04, 1, 0); xfer(8'h00, 1, 32'h1); chk(gate_hs, 0);
    wt(30); chk(gate_hs, 8'h01);
    $display("dead time test done");
  endtask : t_dead
  task t_temp;
    temp_warn <= 1; wt(4); xfer(8'h0C, 0, 0); chk(v[2:1], 2'h1);
    chk(gate_hs, 8'h01);
    temp_sd <= 1; wt(4); chk(gate_hs, 0);
    xfer(8'h0C, 0, 0); chk(v[2], 1);
    xfer(8'h00, 0, 0); chk(v, 32'h1);
    temp_sd <= 0; wt(30); chk(gate_hs, 0);
    xfer(8'h0C, 1, 32'h4); wt(30); chk(gate_hs, 8'h01);
    xfer(8'h0C, 1, 32'h2); xfer(8'h0C, 0, 0); chk(v[1], 1);
    temp_warn <= 0; xfer(8'h0C, 1, 32'h2); xfer(8'h0C, 0, 0); chk(v[2:1], 0);
    $display("temperature test done");
  endtask : t_temp
  task t_supply(input int b);
    if (b == 5) supply_undervoltage_flag <= 1; else supply_overvoltage_flag <= 1;
    wt(4); chk(gate_hs, 0);
    xfer(8'h0C, 0, 0); chk(v[b], 1);
    supply_undervoltage_flag <= 0; supply_overvoltage_flag <= 0; wt(30); chk(gate_hs, 8'h01);
    xfer(8'h0C, 0, 0); chk(v[b], 1);
    xfer(8'h0C, 1, 32'h1 << b); xfer(8'h0C, 0, 0); chk(v[b], 0);
    $display("supply test %0d done", b);
  endtask : t_supply
  task t_oc;
    short_m <= 16'h0001; wt(505); chk(gate_hs, 0);
    xfer(8'h10, 0, 0); chk(v, 32'h1);
    xfer(8'h0C, 0, 0); chk(v[6], 1);
    xfer(8'h00, 0, 0); chk(v, 32'h1);
    wt(30); chk(gate_hs, 0);
    xfer(8'h10, 1, 32'h1); wt(30); chk(gate_hs, 8'h01);
    wt(480); chk(gate_hs, 0);
    short_m <= 0; xfer(8'h10, 1, 32'h1); wt(30); chk(gate_hs, 8'h01);
    xfer(8'h0C, 0, 0); chk(v[6], 0);
    $display("overcurrent test done");
  endtask : t_oc
  task t_ol;
    open_m <= 16'h0001; fw_hs <= 8'h01; wt(40); xfer(8'h14, 0, 0); chk(v, 0);
    fw_hs <= 0; wt(40); xfer(8'h14, 0, 0); chk(v, 32'h1);
    chk(gate_hs, 8'h01);
    xfer(8'h0C, 0, 0); chk(v[6], 1);
    open_m <= 0; xfer(8'h14, 1, 32'h1); xfer(8'h14, 0, 0); chk(v, 0);
    xfer(8'h08, 1, 32'h1); wt(2); chk(led_sel, 2'h1);
    open_m <= 16'h0001; wt(40); xfer(8'h14, 0, 0); chk(v, 0);
    wt(1000); xfer(8'h14, 0, 0); chk(v, 32'h1);
    open_m <= 0; xfer(8'h14, 1, 32'h1); xfer(8'h08, 1, 0);
    $display("open load test done");
  endtask : t_ol
  task t_por;
    hresetn <= 0; wt(2); chk(gate_hs, 0);
    chk(hready, 0);
    hresetn <= 1; xfer(8'h00, 0, 0); chk(v, 0);
    xfer(8'h0C, 0, 0); chk(v[0], 0);
    $display("logic reset test done");
  endtask : t_por
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge hclk) if (hresetn) chk(gate_hs & gate_ls, 8'h00);
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    wt(16);
    hresetn <= 1;
    t_reset(); t_dead(); t_temp(); t_supply(5); t_supply(4); t_oc(); t_ol(); t_por();
    give_verdict();
  end
endmodule : hbs_fault_supervisor_tb_top
